// ---- mse_defines.vh ----
`ifndef MSE_DEFINES_VH
`define MSE_DEFINES_VH
// Register indices
`define MSE_ADDR_CFG      3'h0
`define MSE_ADDR_STAT     3'h1
`define MSE_ADDR_MASK1    3'h2
`define MSE_ADDR_MASK2    3'h3
`define MSE_ADDR_NMIMASK2 3'h4
`define MSE_ADDR_CTRL     3'h5
// Configuration register fields
`define MSE_CFG_MGMT_EN   1
`define MSE_CFG_HOST_EN   2
`define MSE_CFG_NMI_MODE  5
// Mask register fields
`define MSE_MASK1_CHAIN   6
`define MSE_MASK2_RESET   7
`define MSE_NMIMASK2_CLR  7
// Status bits
`define MSE_STAT_LIMIT    0
`define MSE_STAT_OVERTEMP 1
`define MSE_STAT_INTRUDE  2
// Control register fields
`define MSE_CTRL_BYPASS   0
`define MSE_CTRL_RESET    1
// Reset values
`define MSE_RST_CFG       8'h00
`define MSE_RST_MASK      8'h00
`define MSE_RST_CTRL      8'h00
// Timing
`define MSE_CLK_MHZ       200
`define MSE_PULSE_MS      20
`define MSE_PULSE_CYC     (`MSE_PULSE_MS * `MSE_CLK_MHZ * 1000)
`endif

// ---- mse_event_out.v ----
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
// Function
// - Chained management interrupt reaches output if mask bit 6 and config bit 1 allow.
// - High enclosure-open input is an intrusion event, held latched.
// - NMI mask 2 bit 7 pulls enclosure line low at least 20 ms.
// - Master reset output, enabled by mask 2 bit 7, lasts at least 20 ms.
// - Software sets the level of the open-drain power bypass output.
// - Logic works with slow bus clock, down to 1 Hz.
// - Data exchanged over 8-bit bus, bit 0 least significant.
// - Limit violations feed maskable interrupts driving two outputs.
// - Board overtemperature input is an interrupt source.
// - Config bit 5 selects NMI or IRQ mode, bit 2 enables; reset off.
// - Management interrupt output active only with config bit 1; reset off.
// - Board overtemperature input active low, idles high when undriven.
`include "mse_defines.vh"
module mse_event_out #(
   parameter PULSE_CYC = `MSE_PULSE_CYC
) (
   input  wire       sys_clk,
   input  wire       rst_n,
   input  wire [2:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   input  wire       limit_viol,
   input  wire       board_overtemp_in_n,
   input  wire       chained_mgmt_irq_in_n,
   input  wire       intrude_in,
   output wire       intrude_out,
   output wire       intrude_oe,
   output wire       mgmt_irq_out_n,
   output wire       mgmt_irq_oe,
   output wire       host_irq_out,
   output wire       host_irq_oe,
   output wire       master_rst_out,
   output wire       master_rst_oe,
   output wire       bypass_out,
   output wire       bypass_oe
);

   reg [7:0]  cfg_reg;
   reg [7:0]  mask1_reg;
   reg [7:0]  mask2_reg;
   reg [7:0]  nmimask2_reg;
   reg [7:0]  ctrl_reg;
   reg        limit_reg;
   reg        overtemp_reg;
   reg        intrude_reg;
   reg [31:0] clr_cnt_reg;
   reg [31:0] rst_cnt_reg;
   reg        clr_act_reg;
   reg        rst_act_reg;
   reg        mgmt_act_reg;
   reg        host_act_reg;
   reg        bypass_reg;
   reg [31:0] clr_cnt_next;
   reg [31:0] rst_cnt_next;
   reg        clr_act_next;
   reg        rst_act_next;
   reg [7:0]  rdata_next;

   // Register map, indices on reg_addr
   //   0 configuration: b1 management enable, b2 host enable, b5 NMI mode
   //   1 status: b0 limit, b1 overtemperature, b2 intrusion
   //     b0 and b1 write one to clear, b2 cleared by the pulse only
   //   2 first mask: b0..b2 mask sources, b6 masks chained input
   //   3 second mask: b7 enables the master reset pulse
   //   4 clear request: b7 starts the enclosure clear pulse
   //   5 control: b0 bypass drive, b1 starts the master reset pulse
   //     reads give b1 high while the reset pulse runs
   // Unmapped indices read as zero and ignore writes
   // Pulses run from sys_clk, never from the slow host bus clock
   // Pins other than the host pin are open drain: each _out is the level, each _oe the drive
   // The host pin drives high only in NMI mode
   // Bypass and reset pins drive low while their enable is high
   // A running clear pulse also blocks new intrusion events

   wire wr_cfg   = reg_wr && (reg_addr == `MSE_ADDR_CFG);
   wire wr_stat  = reg_wr && (reg_addr == `MSE_ADDR_STAT);
   wire wr_mask1 = reg_wr && (reg_addr == `MSE_ADDR_MASK1);
   wire wr_mask2 = reg_wr && (reg_addr == `MSE_ADDR_MASK2);
   wire wr_nmi2  = reg_wr && (reg_addr == `MSE_ADDR_NMIMASK2);
   wire wr_ctrl  = reg_wr && (reg_addr == `MSE_ADDR_CTRL);

   wire [7:0] stat_bits = {5'h00, intrude_reg, overtemp_reg, limit_reg};

   // Event sources; set wins over write-one-to-clear
   wire limit_set    = limit_viol;
   wire overtemp_set = ~board_overtemp_in_n;
   wire intrude_set  = intrude_in && !clr_act_reg;

   // Pending sources gated by the low mask bits
   wire [2:0] pend = stat_bits[2:0] & ~mask1_reg[2:0];
   wire any_pend = |pend;

   // Configuration register
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg <= `MSE_RST_CFG;
      end else if (wr_cfg) begin
         cfg_reg <= reg_wdata;
      end
   end

   // First mask register, sources and chained input
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask1_reg <= `MSE_RST_MASK;
      end else if (wr_mask1) begin
         mask1_reg <= reg_wdata;
      end
   end

   // Second mask register, reset pulse enable
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask2_reg <= `MSE_RST_MASK;
      end else if (wr_mask2) begin
         mask2_reg <= reg_wdata;
      end
   end

   // Control register, bypass level and reset trigger
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= `MSE_RST_CTRL;
      end else if (wr_ctrl) begin
         ctrl_reg <= reg_wdata;
      end
   end

   // Clear request; bit 7 self-clears once the pulse runs
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         nmimask2_reg <= `MSE_RST_MASK;
      end else if (wr_nmi2) begin
         nmimask2_reg <= reg_wdata;
      end else if (clr_act_reg) begin
         nmimask2_reg[`MSE_NMIMASK2_CLR] <= 1'b0;
      end
   end

   // Limit and overtemperature flags; set beats a clear
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         limit_reg    <= 1'b0;
         overtemp_reg <= 1'b0;
      end else begin
         limit_reg    <= limit_set |
            (limit_reg & ~(wr_stat & reg_wdata[`MSE_STAT_LIMIT]));
         overtemp_reg <= overtemp_set |
            (overtemp_reg & ~(wr_stat & reg_wdata[`MSE_STAT_OVERTEMP]));
      end
   end

   // Intrusion held until the clear pulse is issued
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         intrude_reg <= 1'b0;
      end else if (intrude_set) begin
         intrude_reg <= 1'b1;
      end else if (clr_act_reg) begin
         intrude_reg <= 1'b0;
      end
   end

   // Last cycle of a pulse, shared by both timers
   function pulse_end;
      input [31:0] cnt;
      begin
         pulse_end = (cnt == PULSE_CYC - 1);
      end
   endfunction

   // Intrusion clear pulse timer, next state
   always @* begin
      clr_cnt_next = clr_cnt_reg;
      clr_act_next = clr_act_reg;
      if (clr_act_reg) begin
         if (pulse_end(clr_cnt_reg)) begin
            clr_act_next = 1'b0;
            clr_cnt_next = 32'h0;
         end else begin
            clr_cnt_next = clr_cnt_reg + 32'h1;
         end
      end else if (nmimask2_reg[`MSE_NMIMASK2_CLR]) begin
         clr_act_next = 1'b1;
         clr_cnt_next = 32'h0;
      end
   end

   // Intrusion clear pulse timer flops
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clr_cnt_reg <= 32'h0;
         clr_act_reg <= 1'b0;
      end else begin
         clr_cnt_reg <= clr_cnt_next;
         clr_act_reg <= clr_act_next;
      end
   end

   // Master reset pulse timer, next state
   always @* begin
      rst_cnt_next = rst_cnt_reg;
      rst_act_next = rst_act_reg;
      if (rst_act_reg) begin
         if (pulse_end(rst_cnt_reg)) begin
            rst_act_next = 1'b0;
            rst_cnt_next = 32'h0;
         end else begin
            rst_cnt_next = rst_cnt_reg + 32'h1;
         end
      end else if (wr_ctrl && reg_wdata[`MSE_CTRL_RESET] &&
                   mask2_reg[`MSE_MASK2_RESET]) begin
         rst_act_next = 1'b1;
         rst_cnt_next = 32'h0;
      end
   end

   // Master reset pulse timer flops
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_cnt_reg <= 32'h0;
         rst_act_reg <= 1'b0;
      end else begin
         rst_cnt_reg <= rst_cnt_next;
         rst_act_reg <= rst_act_next;
      end
   end

   // Management interrupt output flop
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mgmt_act_reg <= 1'b0;
      end else begin
         mgmt_act_reg <= cfg_reg[`MSE_CFG_MGMT_EN] & (any_pend |
            (~chained_mgmt_irq_in_n & ~mask1_reg[`MSE_MASK1_CHAIN]));
      end
   end

   // Host interrupt output flop
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         host_act_reg <= 1'b0;
      end else begin
         host_act_reg <= cfg_reg[`MSE_CFG_HOST_EN] & any_pend;
      end
   end

   // Bypass output flop
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bypass_reg <= 1'b0;
      end else begin
         bypass_reg <= ctrl_reg[`MSE_CTRL_BYPASS];
      end
   end

   // Pin drive: open-drain low, open-source high in NMI mode
   assign mgmt_irq_out_n = 1'b0;
   assign mgmt_irq_oe    = mgmt_act_reg;
   assign host_irq_out   = cfg_reg[`MSE_CFG_NMI_MODE];
   assign host_irq_oe    = host_act_reg;
   assign intrude_out    = 1'b0;
   assign intrude_oe     = clr_act_reg;
   assign master_rst_out = 1'b0;
   assign master_rst_oe  = rst_act_reg;
   assign bypass_out     = 1'b0;
   assign bypass_oe      = bypass_reg;

   // Read mux for the addressed register
   always @* begin
      rdata_next = 8'h00;
      case (reg_addr)
         `MSE_ADDR_CFG:      rdata_next = cfg_reg;
         `MSE_ADDR_STAT:     rdata_next = stat_bits;
         `MSE_ADDR_MASK1:    rdata_next = mask1_reg;
         `MSE_ADDR_MASK2:    rdata_next = mask2_reg;
         `MSE_ADDR_NMIMASK2: rdata_next = nmimask2_reg;
         `MSE_ADDR_CTRL:     rdata_next = {6'h00, rst_act_reg,
                                           ctrl_reg[0]};
         default:            rdata_next = 8'h00;
      endcase
   end

   // Read data one cycle after the strobe
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule // mse_event_out

// ---- mse_case_latch.sv ----
`timescale 1ns/1ps
// Enclosure latch beside the chassis line
module mse_case_latch (
   input  wire sys_clk,
   input  wire tamper,
   input  wire intrude_oe,
   input  wire intrude_out,
   output wire intrude_in
);
   reg set_reg = 1'b0;
   // Set by tamper, reset when the line is pulled low
   always @(posedge sys_clk) begin
      if (intrude_oe) set_reg <= 1'b0;
      else if (tamper) set_reg <= 1'b1;
   end
   assign intrude_in = intrude_oe ? intrude_out : set_reg;
endmodule // mse_case_latch

// ---- mse_event_chk.sv ----
`timescale 1ns/1ps
module mse_event_chk #(parameter PULSE_CYC = 16) (
   input wire       sys_clk,
   input wire       rst_n,
   input wire [2:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   input wire       intrude_oe,
   input wire       intrude_out,
   input wire       master_rst_oe,
   input wire       master_rst_out,
   input wire       bypass_oe,
   input wire       bypass_out,
   input wire       mgmt_irq_out_n
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   reg [31:0] ic_reg;
   reg [31:0] rc_reg;
   // Lengths of the two pulses so far
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ic_reg <= 0;
         rc_reg <= 0;
      end else begin
         ic_reg <= intrude_oe ? ic_reg + 1 : 0;
         rc_reg <= master_rst_oe ? rc_reg + 1 : 0;
      end
   end
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside answer cycle");
   unmap_rd_a: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 0)
      else $error("unmapped read not zero");
   intr_start_a: assert property (reg_wr && reg_addr == 3'h4 && reg_wdata[7]
      && !intrude_oe |-> ##2 intrude_oe)
      else $error("clear pulse not started");
   intr_len_a: assert property ($fell(intrude_oe) |-> ic_reg == PULSE_CYC)
      else $error("clear pulse length wrong");
   rst_len_a: assert property ($fell(master_rst_oe) |-> rc_reg == PULSE_CYC)
      else $error("reset pulse length wrong");
   rst_cause_a: assert property ($rose(master_rst_oe) |-> $past(reg_wr)
      && $past(reg_addr) == 3'h5 && $past(reg_wdata[1]))
      else $error("reset pulse without trigger");
   bypass_a: assert property (reg_wr && reg_addr == 3'h5
      |-> ##2 bypass_oe == $past(reg_wdata[0], 2))
      else $error("bypass level wrong");
   drive_low_a: assert property ((intrude_out | master_rst_out
      | bypass_out | mgmt_irq_out_n) == 1'b0)
      else $error("open drain drives high");
endmodule // mse_event_chk

// ---- mse_event_out_tb_top.sv ----
`timescale 1ns/1ps
module mse_event_out_tb_top;
   localparam PULSE_CYC = 16;
   reg sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, lim = 0, ch_n = 1;
   reg bt_n = 1, tamper = 0;
   reg [2:0] reg_addr = 0;
   reg [7:0] reg_wdata = 0, rv;
   wire [7:0] reg_rdata;
   wire io, ioe, mo, moe, ho, hoe, ro, roe, bo, boe, ii;
   integer num_errors = 0, n_tests = 0, i;
   // Rows: cfg, mask1, chained level, expected management oe
   reg [17:0] rows [0:3] = '{{8'h02,8'h00,2'b01}, {8'h00,8'h00,2'b00},
      {8'h02,8'h40,2'b00}, {8'h02,8'h00,2'b10}};
   always #2.5 sys_clk = ~sys_clk;
   mse_case_latch lat (.sys_clk(sys_clk), .tamper(tamper),
      .intrude_oe(ioe), .intrude_out(io), .intrude_in(ii));
   mse_event_out #(.PULSE_CYC(PULSE_CYC)) dut (.sys_clk(sys_clk),
      .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .limit_viol(lim), .board_overtemp_in_n(bt_n),
      .chained_mgmt_irq_in_n(ch_n), .intrude_in(ii), .intrude_out(io),
      .intrude_oe(ioe), .mgmt_irq_out_n(mo), .mgmt_irq_oe(moe),
      .host_irq_out(ho), .host_irq_oe(hoe), .master_rst_out(ro),
      .master_rst_oe(roe), .bypass_out(bo), .bypass_oe(boe));
   task chk(input [7:0] g, input [7:0] e);
      n_tests = n_tests + 1;
      if (g !== e) begin
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         num_errors = num_errors + 1;
      end
   endtask
   task wr(input [2:0] a, input [7:0] d);
      @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk) reg_wr <= 0;
   endtask
   task rd(input [2:0] a);
      @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk) reg_rd <= 0;
      @(negedge sys_clk) rv = reg_rdata;
   endtask
   task wt(input integer n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   task complete_run;
      $display("errors=%0d checks=%0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #30000 num_errors = num_errors + 1;
      complete_run;
   end
   initial begin
      wt(12);
      chk({moe, hoe, roe, boe, ioe}, 0);
      @(posedge sys_clk) rst_n <= 1;
      for (i = 0; i < 4; i = i + 1) begin
         wr(0, rows[i][17:10]);
         wr(2, rows[i][9:2]);
         ch_n <= rows[i][1];
         wt(3);
         chk(moe, rows[i][0]);
      end
      wr(0, 8'h04);
      bt_n <= 0;
      wt(4);
      chk({hoe, ho}, 2'b10);
      wr(0, 8'h24);
      wt(2);
      chk(ho, 1);
      @(posedge sys_clk) lim <= 1;
      wt(2);
      @(posedge sys_clk) {lim, bt_n} <= 2'b01;
      rd(1);
      chk(rv[1:0], 2'b11);
      wr(1, 8'h03);
      rd(1);
      chk(rv[1:0], 2'b00);
      rd(7);
      chk(rv, 0);
      @(posedge sys_clk) tamper <= 1;
      wt(2);
      @(posedge sys_clk) tamper <= 0;
      rd(1);
      chk(rv[2], 1);
      wr(4, 8'h80);
      wt(1);
      chk(ioe, 1);
      wt(PULSE_CYC + 4);
      rd(1);
      chk({rv[2], ii}, 0);
      wr(3, 8'h80);
      wr(5, 8'h02);
      wt(0);
      chk(roe, 1);
      wr(5, 8'h01);
      wt(1);
      chk(boe, 1);
      wt(PULSE_CYC);
      chk(roe, 0);
      complete_run;
   end
endmodule // mse_event_out_tb_top
bind mse_event_out mse_event_chk #(.PULSE_CYC(PULSE_CYC)) chk (.sys_clk,
   .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .intrude_oe, .intrude_out, .master_rst_oe, .master_rst_out,
   .bypass_oe, .bypass_out, .mgmt_irq_out_n);
